// ===== src/sai_pkg.sv
package sai_pkg;

    // ------------------------------------------------------------
    // Fault codes
    // ------------------------------------------------------------
    localparam logic [7:0] FAULT_NONE      = 8'h00;
    localparam logic [7:0] FAULT_PIT       = 8'h14;
    localparam logic [7:0] FAULT_KEY       = 8'h15;
    localparam logic [7:0] FAULT_RECLOSE   = 8'h79;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 10_000_000;
    localparam int RESET_WINDOW_MS = 3000;
    localparam int RESET_WINDOW_CYC = (CLK_HZ / 1000) * RESET_WINDOW_MS;
    localparam int RESET_ACTIONS   = 3;

    // ------------------------------------------------------------
    // Configurations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SAI_CFG_HEAD,
        SAI_CFG_PIT,
        SAI_CFG_HEAD_PIT
    } sai_cfg_e;

    typedef struct packed {
        logic key_contact_ok;
        logic pit_chain_point_ok;
        logic second_to_third_active;
        logic chain_closed;
        logic door_key_contact;
        logic panel_a_inspect;
        logic panel_reset_btn;
        logic terminal_reset;
        logic insp_selected;
        logic run_request;
    } sai_in_s;

endpackage

// ===== src/sai_pulse_counter.sv
`timescale 1ns/1ps
module sai_pulse_counter #(
    parameter int WINDOW_CYC = 30_000_000,
    parameter int ACTIONS    = 3
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Action stream
    input  wire logic action,
    input  wire logic enable,
    output logic      done
);

    logic [31:0] timer_ff;
    logic [3:0]  count_ff;
    logic        done_ff;

    assign done = done_ff;

    // Partial sequences die when the window runs out.
    always_ff @(posedge core_clk) begin
        if (sys_rst || !enable) begin
            timer_ff <= 32'h0000_0000;
            count_ff <= 4'h0;
            done_ff  <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (action) begin
                if (count_ff == 4'(ACTIONS - 1)) begin
                    done_ff  <= 1'b1;
                    count_ff <= 4'h0;
                    timer_ff <= 32'h0000_0000;
                end else begin
                    count_ff <= count_ff + 4'h1;
                    timer_ff <= 32'(WINDOW_CYC);
                end
            end else if (timer_ff != 32'h0000_0000) begin
                timer_ff <= timer_ff - 32'h0000_0001;
            end else begin
                count_ff <= 4'h0;
            end
        end
    end

endmodule

// ===== src/sai_interlock.sv
`timescale 1ns/1ps
module sai_interlock #(
    parameter int WINDOW_CYC = sai_pkg::RESET_WINDOW_CYC,
    parameter bit BISTABLE   = 1'b1
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // Configuration
    input  wire sai_pkg::sai_cfg_e cfg,
    // Field inputs
    input  wire sai_pkg::sai_in_s  fin,
    input  wire logic              roof_access,
    // Outputs
    output logic                   shaft_access_fault,
    output logic [7:0]             fault_code,
    output logic                   run_enable,
    output logic                   light_green
);

    // ------------------------------------------------------------
    // Input edges
    // ------------------------------------------------------------
    logic key_d_ff;
    logic btn_d_ff;
    logic key_ok_d_ff;
    logic latch_open_ff;
    logic armed_ff;
    logic fault_ff;
    logic [7:0] code_ff;
    logic run_ff;
    logic green_ff;
    logic key_action;
    logic btn_action;
    logic key_done;
    logic btn_done;
    logic pit_access;
    logic key_access;
    logic reset_req;
    logic reset_ok;
    logic latch_closed;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            key_d_ff    <= 1'b1;
            btn_d_ff    <= 1'b0;
            key_ok_d_ff <= 1'b1;
        end else begin
            key_d_ff    <= fin.door_key_contact;
            btn_d_ff    <= fin.panel_reset_btn;
            key_ok_d_ff <= fin.key_contact_ok;
        end
    end

    // A reclose of the key contact completes one open/close action.
    assign key_action = fin.door_key_contact && !key_d_ff;
    assign btn_action = fin.panel_reset_btn && !btn_d_ff;

    // pit access, accepting the panel panel_a only with a chain device active.
    assign pit_access = !fin.pit_chain_point_ok ||
                        (fin.panel_a_inspect && fin.second_to_third_active);
    // Roof entry is monitored only outside the reduced-pit configuration.
    // Only the opening edge counts, so a contact held open can still be reset.
    assign key_access = !fin.key_contact_ok && key_ok_d_ff &&
                        ((cfg != sai_pkg::SAI_CFG_PIT) || !roof_access);

    // ------------------------------------------------------------
    // Reset sequence counters
    // ------------------------------------------------------------
    sai_pulse_counter #(
        .WINDOW_CYC (WINDOW_CYC),
        .ACTIONS    (sai_pkg::RESET_ACTIONS)
    ) u_key_cnt (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .action   (key_action),
        .enable   (fault_ff),
        .done     (key_done)
    );

    sai_pulse_counter #(
        .WINDOW_CYC (WINDOW_CYC),
        .ACTIONS    (sai_pkg::RESET_ACTIONS)
    ) u_btn_cnt (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .action   (btn_action),
        .enable   (fault_ff),
        .done     (btn_done)
    );

    assign reset_req = key_done || btn_done || fin.terminal_reset;
    assign latch_closed = BISTABLE ? fin.key_contact_ok : !latch_open_ff;
    // Pit access must be gone and the chain closed before a reset counts.
    assign reset_ok = reset_req && fin.chain_closed && !pit_access;

    // ------------------------------------------------------------
    // Internal latching circuit
    // ------------------------------------------------------------
    // Monostable contacts forget the opening, so hold it here until reset.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            latch_open_ff <= 1'b0;
        end else if (key_access) begin
            latch_open_ff <= 1'b1;
        end else if (reset_ok && !BISTABLE) begin
            latch_open_ff <= 1'b0;
        end
    end

    // Armed after the latch is seen open with a fault pending.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            armed_ff <= 1'b0;
        end else if (!fault_ff) begin
            armed_ff <= 1'b0;
        end else if (!latch_closed) begin
            armed_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Fault latch
    // ------------------------------------------------------------
    // New access wins over a reset in the same cycle.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fault_ff <= 1'b0;
            code_ff  <= sai_pkg::FAULT_NONE;
        end else if (pit_access) begin
            fault_ff <= 1'b1;
            code_ff  <= sai_pkg::FAULT_PIT;
        end else if (key_access) begin
            fault_ff <= 1'b1;
            code_ff  <= sai_pkg::FAULT_KEY;
        end else if (BISTABLE && fault_ff && code_ff == sai_pkg::FAULT_KEY &&
                     latch_closed && armed_ff && !reset_ok) begin
            code_ff  <= sai_pkg::FAULT_RECLOSE;
        end else if (reset_ok) begin
            // A pit fault does not involve the latching circuit.
            if (latch_closed && code_ff != sai_pkg::FAULT_PIT) begin
                code_ff <= sai_pkg::FAULT_RECLOSE;
            end else begin
                fault_ff <= 1'b0;
                code_ff  <= sai_pkg::FAULT_NONE;
            end
        end
    end

    // ------------------------------------------------------------
    // Run permission and light
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            run_ff   <= 1'b0;
            green_ff <= 1'b0;
        end else begin
            run_ff   <= fin.run_request && (!fault_ff || fin.insp_selected);
            green_ff <= fault_ff && fin.insp_selected;
        end
    end

    assign shaft_access_fault = fault_ff;
    assign fault_code         = code_ff;
    assign run_enable         = run_ff;
    assign light_green        = green_ff;

endmodule

// ===== tb/sai_interlock_props.sv
`timescale 1ns/1ps
module sai_interlock_props #(
    parameter int WINDOW_CYC = 50
) (
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              sys_rst,
    // Observed ports
    input wire sai_pkg::sai_cfg_e cfg,
    input wire sai_pkg::sai_in_s  fin,
    input wire logic              roof_access,
    input wire logic              shaft_access_fault,
    input wire logic [7:0]        fault_code,
    input wire logic              run_enable,
    input wire logic              light_green
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // Pit access outranks a key opening, so key checks demand a quiet pit.
    logic pit_ok;
    assign pit_ok = fin.pit_chain_point_ok && !(fin.panel_a_inspect && fin.second_to_third_active);
    key_fault_a: assert property (cfg == sai_pkg::SAI_CFG_HEAD_PIT && !shaft_access_fault && pit_ok
        && $fell(fin.key_contact_ok) |=> fault_code == sai_pkg::FAULT_KEY) else $error("key fault missed");
    pit_fault_a: assert property (cfg == sai_pkg::SAI_CFG_HEAD && !shaft_access_fault && !pit_ok
        |=> shaft_access_fault && fault_code == sai_pkg::FAULT_PIT) else $error("pit fault missed");
    roof_free_a: assert property (cfg == sai_pkg::SAI_CFG_PIT && roof_access && pit_ok
        && !shaft_access_fault |=> !shaft_access_fault) else $error("roof entry faulted");
    no_run_a: assert property (shaft_access_fault && !fin.insp_selected |=> !run_enable)
        else $error("normal run during fault");
    green_light_a: assert property (light_green == $past(shaft_access_fault && fin.insp_selected))
        else $error("light wrong");
    term_clear_a: assert property (shaft_access_fault && fin.terminal_reset && fin.chain_closed && pit_ok
        && !fin.key_contact_ok && !$fell(fin.key_contact_ok) |=> !shaft_access_fault) else $error("no clear");
    reclose_a: assert property (shaft_access_fault && fault_code == sai_pkg::FAULT_KEY && pit_ok
        && $rose(fin.key_contact_ok) && !fin.terminal_reset |=> fault_code == sai_pkg::FAULT_RECLOSE)
        else $error("reclose missed");
    latch_ref_a: assert property (fault_code == sai_pkg::FAULT_RECLOSE && fin.key_contact_ok
        |=> shaft_access_fault) else $error("reset with latch closed");
endmodule
bind sai_interlock sai_interlock_props #(.WINDOW_CYC(WINDOW_CYC)) u_props (.core_clk(core_clk),
    .sys_rst(sys_rst), .cfg(cfg), .fin(fin), .roof_access(roof_access), .light_green(light_green),
    .shaft_access_fault(shaft_access_fault), .fault_code(fault_code), .run_enable(run_enable));

// ===== tb/sai_field_model.sv
`timescale 1ns/1ps
module sai_field_model (
    // Clock
    input  wire logic              core_clk,
    // Levels wanted by the bench
    input  wire sai_pkg::sai_in_s  want,
    input  wire logic              want_roof,
    // Field side
    output sai_pkg::sai_in_s       fin,
    output logic                   roof_access
);
    // The reset key rests closed; button and terminal rest idle.
    logic btn_r  = 1'b0;
    logic door_r = 1'b1;
    logic term_r = 1'b0;
    always_comb begin
        fin = want;
        fin.door_key_contact = door_r;
        fin.panel_reset_btn = btn_r;
        fin.terminal_reset = term_r;
        roof_access = want_roof;
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // One action is an open/close of the key or a press of the button.
    task automatic actions(input bit panel, input int n, input int gap);
        repeat (n) begin
            if (panel) btn_r = 1'b1;
            else door_r = 1'b0;
            step(gap);
            btn_r = 1'b0;
            door_r = 1'b1;
            step(gap);
        end
    endtask
    task automatic term();
        term_r = 1'b1;
        step(1);
        term_r = 1'b0;
    endtask
endmodule

// ===== tb/tb_sai_interlock.sv
`timescale 1ns/1ps
module tb_sai_interlock;
    localparam int WIN = 50;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    sai_pkg::sai_cfg_e cfg = sai_pkg::SAI_CFG_HEAD_PIT;
    sai_pkg::sai_in_s fin;
    sai_pkg::sai_in_s drv = '0;
    logic roof_drv = 1'b0;
    logic roof_access, shaft_access_fault, run_enable, light_green;
    logic [7:0] fault_code;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #50 core_clk = ~core_clk;
    sai_field_model fm (.core_clk(core_clk), .want(drv), .want_roof(roof_drv), .fin(fin),
        .roof_access(roof_access));
    sai_interlock #(.WINDOW_CYC(WIN)) uut (.core_clk(core_clk), .sys_rst(sys_rst), .cfg(cfg), .fin(fin),
        .roof_access(roof_access), .shaft_access_fault(shaft_access_fault), .fault_code(fault_code),
        .run_enable(run_enable), .light_green(light_green));
    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 3000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        // Contacts rest closed and the chain is whole, as in a shaft nobody entered.
        drv.key_contact_ok = 1'b1;
        drv.pit_chain_point_ok = 1'b1;
        drv.chain_closed = 1'b1;
        fm.step(5);
        sys_rst = 1'b0;
        fm.step(1);
        drv.key_contact_ok = 1'b0;
        drv.run_request = 1'b1;
        roof_drv = 1'b1;
        fm.step(3);
        chk(fault_code, sai_pkg::FAULT_KEY);
        chk(run_enable, 8'h00);
        drv.insp_selected = 1'b1;
        fm.step(2);
        chk({run_enable, light_green}, 8'h03);
        drv.insp_selected = 1'b0;
        fm.term();
        fm.step(2);
        chk({shaft_access_fault, run_enable}, 8'h01);
        drv.key_contact_ok = 1'b1;
        drv.run_request = 1'b0;
        roof_drv = 1'b0;
        $display("key test done");
        cfg = sai_pkg::SAI_CFG_HEAD;
        drv.pit_chain_point_ok = 1'b0;
        drv.chain_closed = 1'b0;
        fm.step(2);
        chk(fault_code, sai_pkg::FAULT_PIT);
        drv.pit_chain_point_ok = 1'b1;
        fm.actions(1'b1, 3, 1);
        chk(shaft_access_fault, 8'h01);
        drv.chain_closed = 1'b1;
        fm.actions(1'b1, 3, 1);
        fm.step(2);
        chk(shaft_access_fault, 8'h00);
        drv.panel_a_inspect = 1'b1;
        drv.second_to_third_active = 1'b1;
        fm.step(2);
        chk(fault_code, sai_pkg::FAULT_PIT);
        drv.panel_a_inspect = 1'b0;
        drv.second_to_third_active = 1'b0;
        fm.actions(1'b0, 3, 1);
        fm.step(2);
        chk(shaft_access_fault, 8'h00);
        $display("pit test done");
        // The first of a stale pair of presses falls before the fault; the second must not combine with a later one.
        cfg = sai_pkg::SAI_CFG_HEAD_PIT;
        drv.key_contact_ok = 1'b0;
        fm.actions(1'b1, 2, 1);
        fm.step(WIN + 10);
        fm.actions(1'b1, 1, 1);
        fm.step(2);
        chk(shaft_access_fault, 8'h01);
        fm.actions(1'b1, 2, 1);
        fm.step(2);
        chk(shaft_access_fault, 8'h00);
        drv.key_contact_ok = 1'b1;
        fm.step(2);
        drv.key_contact_ok = 1'b0;
        fm.step(2);
        drv.key_contact_ok = 1'b1;
        fm.step(2);
        chk(fault_code, sai_pkg::FAULT_RECLOSE);
        fm.term();
        fm.step(2);
        chk(shaft_access_fault, 8'h01);
        drv.key_contact_ok = 1'b0;
        fm.step(2);
        fm.term();
        fm.step(2);
        chk(shaft_access_fault, 8'h00);
        drv.key_contact_ok = 1'b1;
        $display("window and reclose tests done");
        cfg = sai_pkg::SAI_CFG_PIT;
        roof_drv = 1'b1;
        drv.key_contact_ok = 1'b0;
        fm.step(3);
        chk(shaft_access_fault, 8'h00);
        $display("roof test done");
        end_sim();
    end
endmodule
